// [bench/dtm_chk_sva.sv]
// Port checker for the transfer mode controller
module dtm_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Register port
  input wire dtm_pkg::dtm_io_req_t io_req,
  input wire logic [31:0] io_rdata,
  input wire logic io_wait,
  // Pins
  input wire dtm_pkg::dtm_pins_in_t pins_in,
  input wire logic input_ack,
  input wire logic [31:0] out_chan,
  input wire logic out_req,
  input wire logic software_trigger_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  import dtm_pkg::*;
  logic [11:0] mode_reg;
  logic wait_reg;
  logic wr_ok;
  logic rd_ok;
  assign wr_ok = io_req.wr && io_req.be == DTM_BE_FULL && !io_wait;
  assign rd_ok = io_req.rd && io_req.be == DTM_BE_FULL;
  // ------------------------------------------------------------
  // Shadow state
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      mode_reg <= 12'h000;
    else if (wr_ok && io_req.addr == DTM_OFS_MODE)
      mode_reg <= io_req.wdata[11:0];
  end
  // Cleared on the raw level, ahead of the synchroniser: lax, never early
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      wait_reg <= 1'b0;
    else if (pins_in.out_ack)
      wait_reg <= 1'b0;
    else if (out_req)
      wait_reg <= 1'b1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_rd_out;
    rd_ok && io_req.addr == DTM_OFS_OUTPUT |=> io_rdata == $past(out_chan);
  endproperty
  a_rd_out: assert property (p_rd_out) else $error("output read-back wrong");
  property p_wr_out;
    wr_ok && io_req.addr == DTM_OFS_OUTPUT && !mode_reg[DTM_B_OUT_FIFO_EN] |=> out_chan == $past(io_req.wdata);
  endproperty
  a_wr_out: assert property (p_wr_out) else $error("direct output write lost");
  property p_be;
    io_req.wr && io_req.be != DTM_BE_FULL && io_req.addr == DTM_OFS_OUTPUT && !mode_reg[DTM_B_OUT_FIFO_EN]
      |=> $stable(out_chan);
  endproperty
  a_be: assert property (p_be) else $error("partial write took effect");
  property p_unmapped;
    rd_ok && (io_req.addr > DTM_OFS_AUX || io_req.addr == DTM_OFS_CWORD) |=> io_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_soft;
    logic v;
    (wr_ok && io_req.addr == DTM_OFS_MODE, v = io_req.wdata[DTM_B_SOFT_TRIG]) |=> software_trigger_pin == v;
  endproperty
  a_soft: assert property (p_soft) else $error("trigger pin wrong");
  property p_req;
    wr_ok && io_req.addr == DTM_OFS_OUTPUT && !mode_reg[DTM_B_OUT_FIFO_EN] && mode_reg[DTM_B_OUT_REQ_EN]
      |=> out_req;
  endproperty
  a_req: assert property (p_req) else $error("no output strobe");
  property p_req_en;
    out_req |-> mode_reg[DTM_B_OUT_REQ_EN] || $past(mode_reg[DTM_B_OUT_REQ_EN]);
  endproperty
  a_req_en: assert property (p_req_en) else $error("strobe while disabled");
  property p_ack_en;
    input_ack |-> (mode_reg[0] && mode_reg[6]) || $past(mode_reg[0] && mode_reg[6]);
  endproperty
  a_ack_en: assert property (p_ack_en) else $error("input ack while disabled");
  property p_hold;
    wait_reg && mode_reg[DTM_B_OUT_ACK_EN] && mode_reg[DTM_B_OUT_FIFO_EN] |=> $stable(out_chan);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved before ack");
  c_ack: cover property (input_ack);
  c_hold: cover property (wait_reg && mode_reg[DTM_B_OUT_FIFO_EN]);
  c_wait: cover property (io_wait);
endmodule

bind dtm_top dtm_chk dtm_chk_inst (.clk_sys(clk_sys), .rstn(rstn), .io_req(io_req), .io_rdata(io_rdata),
  .io_wait(io_wait), .pins_in(pins_in), .input_ack(input_ack), .out_chan(out_chan), .out_req(out_req),
  .software_trigger_pin(software_trigger_pin));

// [bench/dtm_far_end.sv]
// Far-side device model: answers output strobes and keeps the words seen
module dtm_far_end (
  // Clock
  input wire logic clk_sys,
  // From the block
  input wire logic out_req,
  input wire logic [31:0] out_chan,
  // Answer and record
  input wire logic [7:0] ack_delay,
  output logic out_ack,
  output logic [31:0] got [0:63],
  output int n_got
);
  timeunit 1ns;
  timeprecision 1ps;
  // Strobe sampled at the falling edge, where it has settled
  initial begin
    out_ack = 1'b0;
    n_got = 0;
    forever begin
      @(negedge clk_sys);
      if (out_req === 1'b1) begin
        got[n_got] = out_chan;
        n_got++;
        repeat (ack_delay) @(posedge clk_sys);
        out_ack <= 1'b1;
        repeat (2) @(posedge clk_sys);
        out_ack <= 1'b0;
      end
    end
  end
endmodule

// [bench/testbench.sv]
// Self-checking bench for the transfer mode controller
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dtm_pkg::*;
  typedef struct packed {
    logic [5:0] a;
    logic [3:0] b;
    logic w;
    logic [31:0] v;
    logic [31:0] e;
  } dtm_row_t;
  localparam int FD = 32;
  localparam logic [5:0] A_MODE = DTM_OFS_MODE;
  localparam logic [5:0] A_IN = DTM_OFS_INPUT;
  localparam logic [5:0] A_OUT = DTM_OFS_OUTPUT;
  localparam logic [5:0] A_INT = DTM_OFS_INTR;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  dtm_io_req_t io_req = '0;
  logic [31:0] io_rdata;
  logic io_wait;
  logic [31:0] chan_r = 32'h80F0_0F01;
  logic req_r = 1'b0;
  logic trig_r = 1'b0;
  logic out_ack;
  logic input_ack;
  logic [31:0] out_chan;
  logic out_req;
  logic software_trigger_pin;
  logic [31:0] aux_in = 32'h1234_5678;
  logic [31:0] aux_out;
  logic [31:0] got [0:63];
  logic [7:0] ack_delay = 8'h14;
  logic [31:0] d;
  int n_got;
  int mismatches = 0;
  int n_compared = 0;
  int n_ack = 0;
  int stalls = 0;
  int k;
  dtm_row_t rows [0:6];
  dtm_top #(.FIFO_DEPTH(FD)) dtm_top_inst (.clk_sys(clk_sys), .rstn(rstn), .io_req(io_req),
    .io_rdata(io_rdata), .io_wait(io_wait), .pins_in({chan_r, req_r, trig_r, out_ack}),
    .input_ack(input_ack), .out_chan(out_chan), .out_req(out_req),
    .software_trigger_pin(software_trigger_pin), .auxiliary_input(aux_in), .auxiliary_output(aux_out));
  dtm_far_end dtm_far_end_inst (.clk_sys(clk_sys), .out_req(out_req), .out_chan(out_chan),
    .ack_delay(ack_delay), .out_ack(out_ack), .got(got), .n_got(n_got));
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) begin
    if (input_ack === 1'b1)
      n_ack <= n_ack + 1;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Request held until io_wait is seen low, then dropped
  task automatic wrb(input logic [5:0] a, input logic [3:0] b, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk_sys);
    io_req <= '{a, b, 1'b1, 1'b0, v};
    @(negedge clk_sys);
    while (io_wait !== 1'b0 && n < 500) begin
      stalls++;
      n++;
      @(negedge clk_sys);
    end
    @(posedge clk_sys);
    io_req <= '0;
    @(negedge clk_sys);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    wrb(a, DTM_BE_FULL, v);
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    io_req <= '{a, DTM_BE_FULL, 1'b0, 1'b1, 32'h0};
    @(posedge clk_sys);
    io_req <= '0;
    @(negedge clk_sys);
    v = io_rdata;
  endtask
  task automatic setc(input logic [31:0] v);
    @(posedge clk_sys);
    chan_r <= v;
  endtask
  // Pins held six cycles so the synchroniser sees every level
  task automatic pin(input logic t, input logic lvl);
    @(posedge clk_sys);
    if (t)
      trig_r <= lvl;
    else
      req_r <= lvl;
    wt(6);
  endtask
  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    conclude();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rows[0] = '{A_MODE, DTM_BE_FULL, 1'b0, 32'h0, 32'h0};
    rows[1] = '{A_OUT, DTM_BE_FULL, 1'b1, 32'hA55A_0FF0, 32'hA55A_0FF0};
    rows[2] = '{A_OUT, 4'h3, 1'b1, 32'h0000_1111, 32'hA55A_0FF0};
    rows[3] = '{A_IN, DTM_BE_FULL, 1'b1, 32'hFFFF_FFFF, 32'h80F0_0F01};
    rows[4] = '{DTM_OFS_AUX, DTM_BE_FULL, 1'b1, 32'h0BAD_F00D, 32'h1234_5678};
    rows[5] = '{DTM_OFS_CWORD, DTM_BE_FULL, 1'b1, 32'h0000_0036, 32'h0};
    rows[6] = '{6'h24, DTM_BE_FULL, 1'b1, 32'hFFFF_FFFF, 32'h0};
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w)
        wrb(rows[i].a, rows[i].b, rows[i].v);
      rd(rows[i].a, d);
      chk("row read", rows[i].e, d);
    end
    chk("aux out", 32'h0BAD_F00D, aux_out);
    // Strobed input, edge select, acknowledge, input enable
    wr(A_MODE, 32'h0000_0043);
    setc(32'h0000_00A1);
    pin(1'b0, 1'b1);
    pin(1'b0, 1'b0);
    setc(32'h0000_00A2);
    wt(6);
    k = n_ack;
    rd(A_IN, d);
    chk("rise latch", 32'h0000_00A1, d);
    wt(3);
    chk("ack count", k + 1, n_ack);
    wr(A_INT, 32'h0000_1000);
    setc(32'h0000_00A3);
    pin(1'b0, 1'b1);
    rd(A_IN, d);
    chk("rise ignored", 32'h0000_00A1, d);
    pin(1'b0, 1'b0);
    rd(A_IN, d);
    chk("fall latch", 32'h0000_00A3, d);
    wr(A_MODE, 32'h0000_0003);
    setc(32'h0000_00A4);
    pin(1'b0, 1'b1);
    pin(1'b0, 1'b0);
    k = n_ack;
    rd(A_IN, d);
    wt(3);
    chk("halted", 32'h0000_00A3, d);
    chk("no ack", k, n_ack);
    // Triggered FIFO input, overrun, flush
    wr(A_INT, 32'h0);
    pin(1'b1, 1'b1);
    wr(A_MODE, 32'h0000_007B);
    pin(1'b1, 1'b0);
    pin(1'b0, 1'b1);
    pin(1'b0, 1'b0);
    rd(A_INT, d);
    chk("not armed", 32'h0000_4000, d);
    pin(1'b1, 1'b1);
    k = n_ack;
    for (int i = 0; i <= FD; i++) begin
      setc(32'h0000_0100 + i);
      pin(1'b0, 1'b1);
      pin(1'b0, 1'b0);
    end
    chk("fifo acks", k + FD, n_ack);
    rd(A_INT, d);
    chk("fifo full", 32'h0000_8000, d);
    rd(A_MODE, d);
    chk("overrun", 32'h0000_407B, d);
    rd(A_IN, d);
    chk("fifo head", 32'h0000_0100, d);
    wr(A_MODE, 32'h0000_407B);
    rd(A_MODE, d);
    chk("overrun clear", 32'h0000_007B, d);
    wr(A_INT, 32'h0000_2000);
    rd(A_INT, d);
    chk("flushed", 32'h0000_4000, d);
    // Handshake output through the FIFO: slow far side fills it, prompt one drains
    wr(A_MODE, 32'h0000_0580);
    for (int i = 0; i < FD + 8; i++)
      wr(A_OUT, 32'hC000_0000 + i);
    ack_delay = 8'h01;
    for (int i = 0; i < 2000 && n_got < FD + 8; i++)
      wt(1);
    chk("refused", 1, stalls > 0);
    chk("words out", FD + 8, n_got);
    for (int i = 0; i < FD + 8; i++)
      chk("word order", 32'hC000_0000 + i, got[i]);
    chk("last word", 32'hC000_0027, out_chan);
    // Direct strobe, then timer output and underrun
    wr(A_MODE, 32'h0000_0100);
    k = n_got;
    wr(A_OUT, 32'h0000_0F0F);
    wt(4);
    chk("direct strobe", k + 1, n_got);
    wr(DTM_OFS_CNT_B, 32'h0000_0002);
    wr(A_MODE, 32'h0000_0600);
    wr(A_OUT, 32'h5A5A_0001);
    wt(30);
    chk("timed word", 32'h5A5A_0001, out_chan);
    wt(30);
    rd(A_MODE, d);
    chk("underrun", 32'h0001_0600, d);
    wr(A_MODE, 32'h0);
    wr(A_MODE, 32'h0001_0000);
    rd(A_MODE, d);
    chk("underrun clear", 32'h0, d);
    // Timer input sampling; a zero divisor stops it
    wr(DTM_OFS_CNT_A, 32'h0000_0003);
    setc(32'h0000_0B0B);
    wr(A_MODE, 32'h0000_0044);
    wt(80);
    wr(DTM_OFS_CNT_A, 32'h0);
    setc(32'h0000_0C0C);
    wt(40);
    rd(A_IN, d);
    chk("timed sample", 32'h0000_0B0B, d);
    // Software trigger pin, then a second reset
    wr(A_MODE, 32'h0000_0800);
    wt(2);
    chk("pin high", 1, software_trigger_pin);
    @(posedge clk_sys);
    rstn <= 1'b0;
    wt(2);
    chk("pin in reset", 0, software_trigger_pin);
    @(posedge clk_sys);
    rstn <= 1'b1;
    rd(A_MODE, d);
    chk("mode after reset", 32'h0, d);
    chk("out after reset", 32'h0, out_chan);
    conclude();
  end
endmodule

// [pkg/dtm_pkg.sv]
// Constants, register map and carrier types for the digital transfer mode controller
package dtm_pkg;
  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [5:0] DTM_OFS_CNT_A = 6'h00;
  localparam logic [5:0] DTM_OFS_CNT_B = 6'h04;
  localparam logic [5:0] DTM_OFS_CNT_C = 6'h08;
  localparam logic [5:0] DTM_OFS_CWORD = 6'h0C;
  localparam logic [5:0] DTM_OFS_INPUT = 6'h10;
  localparam logic [5:0] DTM_OFS_OUTPUT = 6'h14;
  localparam logic [5:0] DTM_OFS_MODE = 6'h18;
  localparam logic [5:0] DTM_OFS_INTR = 6'h1C;
  localparam logic [5:0] DTM_OFS_AUX = 6'h20;
  localparam logic [3:0] DTM_BE_FULL = 4'hF;
  // ------------------------------------------------------------
  // Transfer mode/status field positions
  // ------------------------------------------------------------
  localparam int DTM_B_IN_ACK_EN = 0;
  localparam int DTM_B_IN_REQ_EN = 1;
  localparam int DTM_B_IN_TIMER_EN = 2;
  localparam int DTM_B_IN_FIFO_EN = 3;
  localparam int DTM_B_TRIG_POL = 4;
  localparam int DTM_B_TRIG_EN = 5;
  localparam int DTM_B_DIN_EN = 6;
  localparam int DTM_B_OUT_ACK_EN = 7;
  localparam int DTM_B_OUT_REQ_EN = 8;
  localparam int DTM_B_OUT_TIMER_EN = 9;
  localparam int DTM_B_OUT_FIFO_EN = 10;
  localparam int DTM_B_SOFT_TRIG = 11;
  localparam int DTM_B_IN_OVERRUN = 14;
  localparam int DTM_B_OUT_UNDERRUN = 16;
  localparam logic [31:0] DTM_MODE_CTRL_MASK = 32'h00000FFF;
  localparam logic [31:0] DTM_MODE_RESET = 32'h00000000;
  // ------------------------------------------------------------
  // Interrupt status/control field positions
  // ------------------------------------------------------------
  localparam int DTM_B_T0_T2 = 10;
  localparam int DTM_B_T1_T2 = 11;
  localparam int DTM_B_REQ_EDGE = 12;
  localparam int DTM_B_FIFO_RST = 13;
  localparam int DTM_B_FIFO_EMPTY = 14;
  localparam int DTM_B_FIFO_FULL = 15;
  localparam logic [31:0] DTM_INTR_STORE_MASK = 32'h00001FFF;
  localparam logic [31:0] DTM_INTR_RESET = 32'h00000000;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int DTM_SYS_CLK_HZ = 40000000;
  localparam int DTM_TIMER_CLK_HZ = 4000000;
  localparam int DTM_TIMER_DIV = DTM_SYS_CLK_HZ / DTM_TIMER_CLK_HZ;
  localparam int DTM_FIFO_DEPTH = 32;
  localparam int DTM_CNT_W = 16;
  // ------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [5:0] addr;
    logic [3:0] be;
    logic wr;
    logic rd;
    logic [31:0] wdata;
  } dtm_io_req_t;

  typedef struct packed {
    logic [31:0] chan;
    logic req;
    logic trig;
    logic out_ack;
  } dtm_pins_in_t;
endpackage

// [rtl/dtm_top.sv]
// Digital transfer mode controller: register port, input/output pacing, FIFOs and pacer timers

// ------------------------------------------------------------
// Synchronous FIFO
// ------------------------------------------------------------
module dtm_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != DEPTH_C);
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else if (flush) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= (wptr_reg == AW'(DEPTH - 1)) ? '0 : wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= (rptr_reg == AW'(DEPTH - 1)) ? '0 : rptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// ------------------------------------------------------------
// Top level
// ------------------------------------------------------------
module dtm_top #(
  parameter int FIFO_DEPTH = dtm_pkg::DTM_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Register port
  input wire dtm_pkg::dtm_io_req_t io_req,
  output logic [31:0] io_rdata,
  output logic io_wait,
  // Input side pins
  input wire dtm_pkg::dtm_pins_in_t pins_in,
  output logic input_ack,
  // Output side pins
  output logic [31:0] out_chan,
  output logic out_req,
  output logic software_trigger_pin,
  // Auxiliary pins
  input wire logic [31:0] auxiliary_input,
  output logic [31:0] auxiliary_output
);
  import dtm_pkg::*;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [$bits(dtm_pins_in_t)-1:0] pin_s1_reg;
  logic [$bits(dtm_pins_in_t)-1:0] pin_s2_reg;
  logic [31:0] aux_s1_reg;
  logic [31:0] aux_s2_reg;
  dtm_pins_in_t pin_sync;
  logic req_d_reg;
  logic trig_d_reg;
  logic oack_d_reg;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      aux_s1_reg <= '0;
      aux_s2_reg <= '0;
      req_d_reg <= 1'b0;
      trig_d_reg <= 1'b0;
      oack_d_reg <= 1'b0;
    end else begin
      pin_s1_reg <= pins_in;
      pin_s2_reg <= pin_s1_reg;
      aux_s1_reg <= auxiliary_input;
      aux_s2_reg <= aux_s1_reg;
      req_d_reg <= pin_sync.req;
      trig_d_reg <= pin_sync.trig;
      oack_d_reg <= pin_sync.out_ack;
    end
  end
  assign pin_sync = dtm_pins_in_t'(pin_s2_reg);

  // ------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------
  logic [31:0] mode_reg;
  logic [31:0] intr_reg;
  logic [11:0] mode_ctl_reg;
  logic overrun_reg;
  logic underrun_reg;
  logic [12:0] intr_ctl_reg;
  logic [31:0] cword_reg;
  logic [31:0] out_chan_reg;
  logic [31:0] aux_out_reg;
  logic [DTM_CNT_W-1:0] cnt_div_reg [3];
  logic full_acc;
  logic wr_hit;
  logic rd_hit;
  logic wr_mode;
  logic wr_out;
  logic rd_in;
  logic fifo_flush;

  assign full_acc = (io_req.be == DTM_BE_FULL);
  assign wr_hit = io_req.wr && full_acc && !io_wait;
  assign rd_hit = io_req.rd && full_acc;
  assign wr_mode = wr_hit && (io_req.addr == DTM_OFS_MODE);
  assign wr_out = wr_hit && (io_req.addr == DTM_OFS_OUTPUT);
  assign rd_in = rd_hit && (io_req.addr == DTM_OFS_INPUT);
  assign fifo_flush = wr_hit && (io_req.addr == DTM_OFS_INTR) && io_req.wdata[DTM_B_FIFO_RST];

  // ------------------------------------------------------------
  // Pacer timers
  // ------------------------------------------------------------
  // A zero divisor parks the counter, so a half-programmed timer never paces.
  logic [3:0] pre_reg;
  logic tick4;
  logic [2:0] cnt_tick;
  logic [2:0] cnt_fall;
  logic [DTM_CNT_W-1:0] cnt_val_reg [3];

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= (pre_reg == 4'(DTM_TIMER_DIV - 1)) ? 4'h0 : pre_reg + 4'h1;
    end
  end
  assign tick4 = (pre_reg == 4'(DTM_TIMER_DIV - 1));
  assign cnt_tick[2] = tick4;
  assign cnt_tick[0] = intr_reg[DTM_B_T0_T2] ? cnt_fall[2] : tick4;
  assign cnt_tick[1] = intr_reg[DTM_B_T1_T2] ? cnt_fall[2] : tick4;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_cnt
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          cnt_div_reg[gi] <= '0;
        end else if (wr_hit && (io_req.addr == 6'(gi * 4))) begin
          cnt_div_reg[gi] <= io_req.wdata[DTM_CNT_W-1:0];
        end
      end
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          cnt_val_reg[gi] <= '0;
        end else if (cnt_div_reg[gi] == '0) begin
          cnt_val_reg[gi] <= '0;
        end else if (cnt_tick[gi]) begin
          cnt_val_reg[gi] <= (cnt_val_reg[gi] <= DTM_CNT_W'(1)) ? cnt_div_reg[gi] : cnt_val_reg[gi] - 1'b1;
        end
      end
      assign cnt_fall[gi] = cnt_tick[gi] && (cnt_div_reg[gi] != '0) && (cnt_val_reg[gi] == DTM_CNT_W'(2)
                            || cnt_div_reg[gi] == DTM_CNT_W'(1));
    end
  endgenerate

  // ------------------------------------------------------------
  // Input path
  // ------------------------------------------------------------
  logic din_en;
  logic armed_reg;
  logic req_edge;
  logic trig_edge;
  logic sample;
  logic [31:0] in_latch_reg;
  logic inf_in_ready;
  logic inf_out_valid;
  logic [31:0] inf_out_data;
  logic in_push;
  logic overrun_set;

  assign din_en = mode_reg[DTM_B_DIN_EN];
  assign req_edge = intr_reg[DTM_B_REQ_EDGE] ? (req_d_reg && !pin_sync.req)
                                             : (!req_d_reg && pin_sync.req);
  assign trig_edge = mode_reg[DTM_B_TRIG_POL] ? (!trig_d_reg && pin_sync.trig)
                                              : (trig_d_reg && !pin_sync.trig);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      armed_reg <= 1'b0;
    end else if (!din_en) begin
      armed_reg <= 1'b0;
    end else if (!mode_reg[DTM_B_TRIG_EN] || trig_edge) begin
      armed_reg <= 1'b1;
    end
  end

  assign sample = din_en && armed_reg &&
                  ((mode_reg[DTM_B_IN_REQ_EN] && req_edge) ||
                   (mode_reg[DTM_B_IN_TIMER_EN] && cnt_fall[0]));

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      in_latch_reg <= '0;
    end else if (sample) begin
      in_latch_reg <= pin_sync.chan;
    end
  end

  assign in_push = sample && mode_reg[DTM_B_IN_FIFO_EN];
  assign overrun_set = in_push && !inf_in_ready;

  dtm_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_in_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .flush(fifo_flush),
    .in_valid(in_push),
    .in_ready(inf_in_ready),
    .in_data(pin_sync.chan),
    .out_valid(inf_out_valid),
    .out_ready(rd_in && mode_reg[DTM_B_IN_FIFO_EN]),
    .out_data(inf_out_data)
  );

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      input_ack <= 1'b0;
    end else begin
      input_ack <= mode_reg[DTM_B_IN_ACK_EN] && din_en &&
                   ((in_push && inf_in_ready) || (rd_in && !mode_reg[DTM_B_IN_FIFO_EN]));
    end
  end

  // ------------------------------------------------------------
  // Output path
  // ------------------------------------------------------------
  logic busy_reg;
  logic ofi_in_ready;
  logic ofi_out_valid;
  logic [31:0] ofi_out_data;
  logic out_fifo_en;
  logic advance;
  logic out_load;
  logic underrun_set;
  logic oack_edge;

  assign out_fifo_en = mode_reg[DTM_B_OUT_FIFO_EN];
  // Host write stalls while the output FIFO is full instead of losing the word.
  assign io_wait = io_req.wr && full_acc && (io_req.addr == DTM_OFS_OUTPUT) && out_fifo_en && !ofi_in_ready;
  assign advance = out_fifo_en && !busy_reg &&
                   (mode_reg[DTM_B_OUT_TIMER_EN] ? cnt_fall[1] : 1'b1);
  assign underrun_set = advance && mode_reg[DTM_B_OUT_TIMER_EN] && !ofi_out_valid;
  assign out_load = (advance && ofi_out_valid) || (wr_out && !out_fifo_en);
  assign oack_edge = !oack_d_reg && pin_sync.out_ack;

  dtm_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_out_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .flush(1'b0),
    .in_valid(wr_out && out_fifo_en),
    .in_ready(ofi_in_ready),
    .in_data(io_req.wdata),
    .out_valid(ofi_out_valid),
    .out_ready(advance),
    .out_data(ofi_out_data)
  );

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      out_chan_reg <= '0;
    end else if (out_load) begin
      out_chan_reg <= out_fifo_en ? ofi_out_data : io_req.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      out_req <= 1'b0;
    end else begin
      out_req <= out_load && mode_reg[DTM_B_OUT_REQ_EN];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busy_reg <= 1'b0;
    end else if (out_load && mode_reg[DTM_B_OUT_REQ_EN] && mode_reg[DTM_B_OUT_ACK_EN]) begin
      busy_reg <= 1'b1;
    end else if (oack_edge || !mode_reg[DTM_B_OUT_ACK_EN]) begin
      busy_reg <= 1'b0;
    end
  end

  assign out_chan = out_chan_reg;
  assign software_trigger_pin = mode_reg[DTM_B_SOFT_TRIG];
  assign auxiliary_output = aux_out_reg;

  // ------------------------------------------------------------
  // Control and status registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mode_ctl_reg <= DTM_MODE_RESET[11:0];
    end else if (wr_mode) begin
      mode_ctl_reg <= io_req.wdata[11:0];
    end
  end

  // Set wins over a write-one clear in the same cycle.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      overrun_reg <= 1'b0;
      underrun_reg <= 1'b0;
    end else begin
      if (overrun_set) begin
        overrun_reg <= 1'b1;
      end else if (wr_mode && io_req.wdata[DTM_B_IN_OVERRUN]) begin
        overrun_reg <= 1'b0;
      end
      if (underrun_set) begin
        underrun_reg <= 1'b1;
      end else if (wr_mode && io_req.wdata[DTM_B_OUT_UNDERRUN]) begin
        underrun_reg <= 1'b0;
      end
    end
  end
  assign mode_reg = {15'h0000, underrun_reg, 1'b0, overrun_reg, 2'h0, mode_ctl_reg};

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      intr_ctl_reg <= DTM_INTR_RESET[12:0];
      cword_reg <= '0;
      aux_out_reg <= '0;
    end else if (wr_hit) begin
      case (io_req.addr)
        DTM_OFS_INTR: intr_ctl_reg <= io_req.wdata[12:0];
        DTM_OFS_CWORD: cword_reg <= io_req.wdata;
        DTM_OFS_AUX: aux_out_reg <= io_req.wdata;
        default: ;
      endcase
    end
  end
  assign intr_reg = {16'h0000, !inf_in_ready, !inf_out_valid, 1'b0, intr_ctl_reg};

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  // Input reads show the FIFO head, the last latched word, or live levels.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      io_rdata <= '0;
    end else if (rd_hit) begin
      case (io_req.addr)
        DTM_OFS_CNT_A: io_rdata <= 32'(cnt_val_reg[0]);
        DTM_OFS_CNT_B: io_rdata <= 32'(cnt_val_reg[1]);
        DTM_OFS_CNT_C: io_rdata <= 32'(cnt_val_reg[2]);
        DTM_OFS_INPUT: begin
          if (mode_reg[DTM_B_IN_FIFO_EN]) begin
            io_rdata <= inf_out_valid ? inf_out_data : 32'h00000000;
          end else if (mode_reg[DTM_B_IN_REQ_EN] || mode_reg[DTM_B_IN_TIMER_EN]) begin
            io_rdata <= in_latch_reg;
          end else begin
            io_rdata <= pin_sync.chan;
          end
        end
        DTM_OFS_OUTPUT: io_rdata <= out_chan_reg;
        DTM_OFS_MODE: io_rdata <= mode_reg;
        DTM_OFS_INTR: io_rdata <= intr_reg;
        DTM_OFS_AUX: io_rdata <= aux_s2_reg;
        default: io_rdata <= 32'h00000000;
      endcase
    end
  end
endmodule
